// [mpt_core.sv]
// control core: program counter, return stack, status word, branch tests,
// single-level interrupt logic and timer flag handling
// assumes the instruction decoder drives one-cycle command strobes and pulses
// instr_end_in on the last (second, for two-cycle) cycle of each instruction
//
// What this block does
// - only the low 10 program counter bits address on-chip program memory
// - reset clears the program counter to zero
// - call or interrupt saves the program counter at the 3-bit stack pointer
// - stack holds eight entries with four status bits; pointer increments after push
// - stack pointer wraps 111 to 000 and 000 to 111
// - a return decrements the pointer, then loads the counter from that entry
// - upper status bits pushed always, restored only by the restoring return
// - status word: pointer, constant one, bank select, three flags
// - user flag zero, auxiliary carry and carry sit in bits 5 to 7
// - branch tests cover accumulator, carry, flags, timer flag, test and irq inputs
// - active-low irq level sampled at instruction end; vectors to location 3
// - single level: further requests ignored until restoring return's second cycle
// - external wins over timer; timer request stays pending until cleared
// - reset disables external irq; input stays testable while disabled
// - 8-bit counter loaded and read, halted by reset or stop, wraps
// - each wrap sets the timer flag and latches a request; test clears flag
// - separate timer irq enable; overflow vectors to location 7
// - event mode counts falling edges of the event test input
// - timer mode increments every 32 machine cycles; start clears prescaler
// - reset stops counter, clears flags, selects bank 0, disables both irqs
`timescale 1ns/1ps
module mpt_core import mpt_pkg::*; (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic irq_n_in,
    input wire logic test_input_a_in,
    input wire logic event_test_input_in,
    input wire logic instr_end_in,
    input wire logic pc_inc_in,
    input wire logic jump_in,
    input wire logic call_in,
    input wire logic [11:0] target_addr_in,
    input wire logic return_plain_in,
    input wire logic return_restore_status_in,
    input wire logic [7:0] acc_in,
    input wire logic status_load_in,
    input wire logic bank_sel_we_in,
    input wire logic bank_sel_in,
    input wire logic alu_flags_we_in,
    input wire logic carry_in,
    input wire logic aux_carry_in,
    input wire logic user_flag_zero_cpl_in,
    input wire logic user_flag_zero_clr_in,
    input wire logic user_flag_one_cpl_in,
    input wire logic user_flag_one_clr_in,
    input wire logic ext_irq_enable_instr_in,
    input wire logic ext_irq_disable_instr_in,
    input wire logic timer_irq_enable_instr_in,
    input wire logic timer_irq_disable_instr_in,
    input wire logic timer_load_in,
    input wire logic timer_start_instr_in,
    input wire logic event_count_start_instr_in,
    input wire logic counter_stop_instr_in,
    input wire logic [3:0] cond_sel_in,
    input wire logic [2:0] acc_bit_sel_in,
    input wire logic cond_eval_in,
    output logic [11:0] pc_out,
    output logic [9:0] rom_addr_out,
    output logic [7:0] program_status_word_out,
    output logic user_flag_one_out,
    output logic [7:0] timer_count_out,
    output logic timer_flag_out,
    output logic cond_true_out,
    output logic vector_taken_out,
    output logic irq_in_service_out
);
    typedef struct packed {
        logic [11:0] pc;
        logic [2:0] sp;
        logic register_bank_select;
        logic user_flag_zero;
        logic user_flag_one;
        logic aux_carry_flag;
        logic carry_flag;
        logic ext_en;
        logic tmr_en;
        logic in_service;
        logic tflag;
        logic tpend;
        logic restore;
        logic vec;
        mpt_state_t state;
    } mpt_core_state_t;

    mpt_core_state_t st_reg;
    mpt_core_state_t st_next;

    logic [15:0] stk_rd;
    logic [15:0] stk_wdata;
    logic [2:0] stk_rd_idx;
    logic push;
    logic take_ext;
    logic take_tmr;
    logic tmr_ovf;
    logic [7:0] status_now;

    function automatic logic [7:0] status_pack(input mpt_core_state_t s);
        logic [7:0] w;
        w = 8'h00;
        w[MPT_ST_SP_HI:MPT_ST_SP_LO] = s.sp;
        w[MPT_ST_ONE] = 1'b1;
        w[MPT_ST_BANK] = s.register_bank_select;
        w[MPT_ST_UF0] = s.user_flag_zero;
        w[MPT_ST_AUX] = s.aux_carry_flag;
        w[MPT_ST_CARRY] = s.carry_flag;
        return w;
    endfunction

    function automatic logic [15:0] stack_entry(input logic [11:0] pc, input logic [7:0] sw);
        return {sw[7:4], pc};
    endfunction

    assign status_now = status_pack(st_reg);
    assign stk_wdata = stack_entry(st_reg.pc, status_now);

    // interrupt acceptance at instruction end, external first
    always_comb begin
        take_ext = 1'b0;
        take_tmr = 1'b0;
        if (instr_end_in && !st_reg.in_service && st_reg.state == MPT_S_IDLE) begin
            if (st_reg.ext_en && !irq_n_in) begin
                take_ext = 1'b1;
            end else if (st_reg.tmr_en && st_reg.tpend) begin
                take_tmr = 1'b1;
            end
        end
    end

    assign push = call_in || take_ext || take_tmr;

    // stack read index tracks the pointer after a pending decrement
    assign stk_rd_idx = st_reg.sp - 3'h1;

    always_comb begin
        st_next = st_reg;
        st_next.vec = 1'b0;
        if (pc_inc_in) begin
            st_next.pc = st_reg.pc + 12'h001;
        end
        if (jump_in) begin
            st_next.pc = target_addr_in;
        end
        if (alu_flags_we_in) begin
            st_next.carry_flag = carry_in;
            st_next.aux_carry_flag = aux_carry_in;
        end
        if (bank_sel_we_in) begin
            st_next.register_bank_select = bank_sel_in;
        end
        if (user_flag_zero_clr_in) begin
            st_next.user_flag_zero = 1'b0;
        end else if (user_flag_zero_cpl_in) begin
            st_next.user_flag_zero = !st_reg.user_flag_zero;
        end
        if (user_flag_one_clr_in) begin
            st_next.user_flag_one = 1'b0;
        end else if (user_flag_one_cpl_in) begin
            st_next.user_flag_one = !st_reg.user_flag_one;
        end
        if (status_load_in) begin
            st_next.sp = acc_in[MPT_ST_SP_HI:MPT_ST_SP_LO];
            st_next.register_bank_select = acc_in[MPT_ST_BANK];
            st_next.user_flag_zero = acc_in[MPT_ST_UF0];
            st_next.aux_carry_flag = acc_in[MPT_ST_AUX];
            st_next.carry_flag = acc_in[MPT_ST_CARRY];
        end
        if (ext_irq_enable_instr_in) begin
            st_next.ext_en = 1'b1;
        end else if (ext_irq_disable_instr_in) begin
            st_next.ext_en = 1'b0;
        end
        if (timer_irq_enable_instr_in) begin
            st_next.tmr_en = 1'b1;
        end else if (timer_irq_disable_instr_in) begin
            st_next.tmr_en = 1'b0;
        end
        // timer flag: a new overflow wins over the clearing test
        if (cond_eval_in && cond_sel_in == 4'(MPT_C_TFLAG)) begin
            st_next.tflag = 1'b0;
        end
        if (timer_irq_disable_instr_in || take_tmr) begin
            st_next.tpend = 1'b0;
        end
        if (tmr_ovf) begin
            st_next.tflag = 1'b1;
            st_next.tpend = 1'b1;
        end
        if (push) begin
            st_next.sp = st_reg.sp + 3'h1;
        end
        if (call_in) begin
            st_next.pc = target_addr_in;
        end
        if (take_ext || take_tmr) begin
            st_next.pc = take_ext ? MPT_VEC_EXT : MPT_VEC_TMR;
            st_next.in_service = 1'b1;
            st_next.vec = 1'b1;
        end
        case (st_reg.state)
            MPT_S_IDLE: begin
                if (return_plain_in || return_restore_status_in) begin
                    st_next.sp = st_reg.sp - 3'h1;
                    st_next.restore = return_restore_status_in;
                    st_next.state = MPT_S_RET2;
                end
            end
            MPT_S_RET2: begin
                st_next.pc = stk_rd[11:0];
                if (st_reg.restore) begin
                    st_next.carry_flag = stk_rd[15];
                    st_next.aux_carry_flag = stk_rd[14];
                    st_next.user_flag_zero = stk_rd[13];
                    st_next.register_bank_select = stk_rd[12];
                    st_next.in_service = 1'b0;
                end
                st_next.state = MPT_S_IDLE;
            end
            default: begin
                st_next.state = MPT_S_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_reg <= '0;
            st_reg.pc <= MPT_PC_RESET;
            st_reg.sp <= MPT_SP_RESET;
            st_reg.state <= MPT_S_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // branch condition evaluation
    always_comb begin
        case (mpt_cond_t'(cond_sel_in))
            MPT_C_ACC_NZ: cond_true_out = |acc_in;
            MPT_C_ACC_BIT: cond_true_out = acc_in[acc_bit_sel_in];
            MPT_C_CARRY_CLR: cond_true_out = !st_reg.carry_flag;
            MPT_C_CARRY_SET: cond_true_out = st_reg.carry_flag;
            MPT_C_UF0: cond_true_out = st_reg.user_flag_zero;
            MPT_C_UF1: cond_true_out = st_reg.user_flag_one;
            MPT_C_TFLAG: cond_true_out = st_reg.tflag;
            MPT_C_TA_LOW: cond_true_out = !test_input_a_in;
            MPT_C_TA_HIGH: cond_true_out = test_input_a_in;
            MPT_C_EV_LOW: cond_true_out = !event_test_input_in;
            MPT_C_EV_HIGH: cond_true_out = event_test_input_in;
            MPT_C_IRQ_LOW: cond_true_out = !irq_n_in;
            default: cond_true_out = 1'b0;
        endcase
    end

    mpt_stack u_stack (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .wr_in(push),
        .wr_idx_in(st_reg.sp),
        .wr_data_in(stk_wdata),
        .rd_idx_in(stk_rd_idx),
        .rd_data_out(stk_rd)
    );

    mpt_tcnt u_tcnt (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .load_in(timer_load_in),
        .load_data_in(acc_in),
        .start_timer_in(timer_start_instr_in),
        .start_event_in(event_count_start_instr_in),
        .stop_in(counter_stop_instr_in),
        .event_in(event_test_input_in),
        .count_out(timer_count_out),
        .overflow_out(tmr_ovf)
    );

    assign pc_out = st_reg.pc;
    assign rom_addr_out = st_reg.pc[MPT_ROM_W-1:0];
    assign program_status_word_out = status_now;
    assign user_flag_one_out = st_reg.user_flag_one;
    assign timer_flag_out = st_reg.tflag;
    assign vector_taken_out = st_reg.vec;
    assign irq_in_service_out = st_reg.in_service;

    default clocking mpt_cb @(posedge core_clk_in);
    endclocking
    default disable iff (!nrst_in);

    sequence s_ret_start;
        st_reg.state == MPT_S_IDLE && (return_plain_in || return_restore_status_in);
    endsequence
    sequence s_ret_load;
        st_reg.state == MPT_S_RET2 ##1 pc_out == $past(stk_rd[11:0]);
    endsequence
    sequence s_irq_take;
        take_ext || take_tmr;
    endsequence
    sequence s_irq_entered;
        vector_taken_out && irq_in_service_out ##1 !vector_taken_out;
    endsequence

    a_ext_vector_loc: assert property (take_ext |=> pc_out == MPT_VEC_EXT)
        else $error("external request did not vector to 3");
    a_tmr_vector_loc: assert property ((take_tmr && !tmr_ovf)
        |=> pc_out == MPT_VEC_TMR && !st_reg.tpend)
        else $error("timer request did not vector to 7 and clear pending");
    a_ext_over_timer: assert property (take_tmr |-> !(st_reg.ext_en && !irq_n_in))
        else $error("timer vector taken over a live external request");
    a_single_level: assert property ((irq_in_service_out && st_reg.state == MPT_S_IDLE)
        |=> irq_in_service_out && !vector_taken_out)
        else $error("request accepted while in service");
    a_vector_walk: assert property (s_irq_take |=> s_irq_entered)
        else $error("vector pulse or service flag wrong after acceptance");
    a_restore_ends_svc: assert property ((st_reg.state == MPT_S_RET2 && st_reg.restore)
        |=> !irq_in_service_out)
        else $error("restoring return left service flag set");
    a_ret_sp_dec: assert property (s_ret_start |=> st_reg.sp == $past(st_reg.sp) - 3'h1)
        else $error("return did not step the stack pointer back");
    a_push_sp_inc: assert property ((push && !status_load_in && st_reg.state == MPT_S_IDLE
        && !return_plain_in && !return_restore_status_in)
        |=> st_reg.sp == $past(st_reg.sp) + 3'h1)
        else $error("stack pointer did not advance after push");
    a_ret_sequence: assert property (s_ret_start |=> s_ret_load)
        else $error("return did not load counter from decremented entry");
    a_plain_ret_psw: assert property ((st_reg.state == MPT_S_RET2 && !st_reg.restore
        && !alu_flags_we_in && !status_load_in && !bank_sel_we_in
        && !user_flag_zero_cpl_in && !user_flag_zero_clr_in)
        |=> program_status_word_out[7:4] == $past(program_status_word_out[7:4]))
        else $error("plain return changed status flags");
    a_status_bit_one: assert property (program_status_word_out[MPT_ST_ONE])
        else $error("status bit 3 not one");
    a_tflag_on_wrap: assert property (tmr_ovf |=> timer_flag_out && st_reg.tpend)
        else $error("overflow did not set timer flag and pending request");
    a_tflag_clear: assert property ((cond_eval_in && cond_sel_in == 4'(MPT_C_TFLAG)
        && !tmr_ovf) |=> !timer_flag_out)
        else $error("timer flag test did not clear the flag");
    a_tmr_dis_drop: assert property ((timer_irq_disable_instr_in && !tmr_ovf)
        |=> !st_reg.tpend)
        else $error("timer disable did not drop the pending request");
endmodule

// [mpt_ext_src.sv]
// far-side model: wired-or interrupt source and event source on the event test input
// assumes requests from the bench are one-cycle pulses or levels sampled on the core clock
`timescale 1ns/1ps
module mpt_ext_src (
    input wire logic core_clk_in,
    input wire logic irq_req_in,
    input wire logic event_req_in,
    output logic irq_n_out,
    output logic event_out
);
    logic [1:0] irq_low_reg;
    logic [2:0] ev_cnt_reg;

    initial begin
        irq_n_out = 1'b1;
        event_out = 1'b1;
        irq_low_reg = 2'h0;
        ev_cnt_reg = 3'h0;
    end

    // once pulled low the line stays low three cycles at least
    always @(posedge core_clk_in) begin
        if (irq_req_in || (!irq_n_out && irq_low_reg != 2'h3)) begin
            irq_n_out <= 1'b0;
            irq_low_reg <= (irq_low_reg == 2'h3) ? 2'h3 : irq_low_reg + 2'h1;
        end else begin
            irq_n_out <= 1'b1;
            irq_low_reg <= 2'h0;
        end
    end

    // low two cycles, then high five before the next pulse
    always @(posedge core_clk_in) begin
        if (ev_cnt_reg == 3'h0 && event_req_in) begin
            ev_cnt_reg <= 3'h6;
            event_out <= 1'b0;
        end else if (ev_cnt_reg != 3'h0) begin
            ev_cnt_reg <= ev_cnt_reg - 3'h1;
            event_out <= (ev_cnt_reg != 3'h6);
        end
    end
endmodule

// [mpt_pkg.sv]
// constants and types shared by the control core, its stack store and its counter
// assumes one machine cycle per core clock edge
package mpt_pkg;
    localparam int MPT_PC_W = 12;
    localparam int MPT_ROM_W = 10;
    localparam int MPT_SP_W = 3;
    localparam int MPT_STK_DEPTH = 8;
    localparam int MPT_ENTRY_W = 16;
    localparam logic [11:0] MPT_PC_RESET = 12'h000;
    localparam logic [11:0] MPT_VEC_EXT = 12'h003;
    localparam logic [11:0] MPT_VEC_TMR = 12'h007;
    localparam logic [2:0] MPT_SP_RESET = 3'h0;
    // status word field positions
    localparam int MPT_ST_SP_LO = 0;
    localparam int MPT_ST_SP_HI = 2;
    localparam int MPT_ST_ONE = 3;
    localparam int MPT_ST_BANK = 4;
    localparam int MPT_ST_UF0 = 5;
    localparam int MPT_ST_AUX = 6;
    localparam int MPT_ST_CARRY = 7;
    localparam logic [7:0] MPT_CNT_RESET = 8'h00;
    localparam logic [7:0] MPT_CNT_MAX = 8'hff;
    localparam int MPT_PRESCALE = 32;
    localparam logic [4:0] MPT_PRE_LAST = 5'(MPT_PRESCALE - 1);
    localparam logic [4:0] MPT_PRE_RESET = 5'h00;

    typedef enum logic [3:0] {
        MPT_C_ACC_NZ,
        MPT_C_ACC_BIT,
        MPT_C_CARRY_CLR,
        MPT_C_CARRY_SET,
        MPT_C_UF0,
        MPT_C_UF1,
        MPT_C_TFLAG,
        MPT_C_TA_LOW,
        MPT_C_TA_HIGH,
        MPT_C_EV_LOW,
        MPT_C_EV_HIGH,
        MPT_C_IRQ_LOW
    } mpt_cond_t;

    typedef enum logic [0:0] {
        MPT_S_IDLE,
        MPT_S_RET2
    } mpt_state_t;
endpackage

// [mpt_stack.sv]
// eight-entry return stack store (program counter plus upper status bits)
// assumes writes and reads are sequenced by the control core
`timescale 1ns/1ps
module mpt_stack import mpt_pkg::*; (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic wr_in,
    input wire logic [2:0] wr_idx_in,
    input wire logic [15:0] wr_data_in,
    input wire logic [2:0] rd_idx_in,
    output logic [15:0] rd_data_out
);
    typedef struct packed {
        logic [MPT_STK_DEPTH-1:0][MPT_ENTRY_W-1:0] mem;
        logic [15:0] rd;
    } mpt_stk_state_t;

    mpt_stk_state_t st_reg;
    mpt_stk_state_t st_next;

    always_comb begin
        st_next = st_reg;
        if (wr_in) begin
            st_next.mem[wr_idx_in] = wr_data_in;
        end
        // read of the entry the pointer will name next cycle
        st_next.rd = st_next.mem[rd_idx_in];
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rd_data_out = st_reg.rd;
endmodule

// [mpt_tcnt.sv]
// 8-bit timer / event counter with divide-by-32 prescaler
// assumes event input is synchronous and sampled once per machine cycle
`timescale 1ns/1ps
module mpt_tcnt import mpt_pkg::*; (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic load_in,
    input wire logic [7:0] load_data_in,
    input wire logic start_timer_in,
    input wire logic start_event_in,
    input wire logic stop_in,
    input wire logic event_in,
    output logic [7:0] count_out,
    output logic overflow_out
);
    typedef struct packed {
        logic [7:0] cnt;
        logic [4:0] pre;
        logic run;
        logic ev_mode;
        logic ev_prev;
        logic ovf;
    } mpt_tc_state_t;

    mpt_tc_state_t st_reg;
    mpt_tc_state_t st_next;
    logic tick;

    always_comb begin
        st_next = st_reg;
        st_next.ovf = 1'b0;
        st_next.ev_prev = event_in;
        tick = 1'b0;
        if (st_reg.run && st_reg.ev_mode) begin
            tick = st_reg.ev_prev && !event_in;
        end else if (st_reg.run) begin
            st_next.pre = st_reg.pre + 5'h01;
            tick = (st_reg.pre == MPT_PRE_LAST);
        end
        if (tick) begin
            st_next.cnt = st_reg.cnt + 8'h01;
            st_next.ovf = (st_reg.cnt == MPT_CNT_MAX);
        end
        if (load_in) begin
            st_next.cnt = load_data_in;
        end
        if (start_timer_in) begin
            st_next.run = 1'b1;
            st_next.ev_mode = 1'b0;
            st_next.pre = MPT_PRE_RESET;
        end else if (start_event_in) begin
            st_next.run = 1'b1;
            st_next.ev_mode = 1'b1;
        end else if (stop_in) begin
            st_next.run = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign count_out = st_reg.cnt;
    assign overflow_out = st_reg.ovf;

    a_prescale_tick: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        (st_reg.run && !st_reg.ev_mode && st_reg.pre != MPT_PRE_LAST && !load_in)
        |=> $stable(st_reg.cnt))
        else $error("timer count moved between prescaler ends");
    a_wrap_overflow: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        (tick && st_reg.cnt == MPT_CNT_MAX && !load_in) |=> (overflow_out && count_out == 8'h00))
        else $error("counter wrap did not raise overflow");
endmodule

// [tb_top.sv]
// self-checking bench for the control core: stack, status word, tests, interrupts, counter
// assumes one machine cycle per core clock and one-cycle command strobes
`timescale 1ns/1ps
module tb_top;
    import mpt_pkg::*;
    logic core_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [21:0] cmd = 22'h0;
    logic [11:0] target = 12'h000;
    logic [7:0] acc = 8'h00;
    logic bank_sel = 1'b0, carry = 1'b0, aux = 1'b0, test_a = 1'b0;
    logic [3:0] cond_sel = 4'h0;
    logic [2:0] acc_bit_sel = 3'h0;
    logic irq_req = 1'b0, ev_req = 1'b0;
    wire irq_n, ev_line, uf1, tflag, cond_true, vec, in_svc;
    wire [11:0] pc;
    wire [9:0] rom;
    wire [7:0] program_status, cnt;
    int n_mismatch = 0, checked = 0, cycles = 0, i, n;
    logic [11:0] stk_pc[8];
    logic [3:0] stk_up[8];
    logic [11:0] pc_m = 12'h000;
    logic [3:0] up_m = 4'h0;
    logic [2:0] sp_m = 3'h0;

    mpt_ext_src i_src (.core_clk_in(core_clk_in), .irq_req_in(irq_req),
        .event_req_in(ev_req), .irq_n_out(irq_n), .event_out(ev_line));

    mpt_core i_dut (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .irq_n_in(irq_n),
        .test_input_a_in(test_a), .event_test_input_in(ev_line), .instr_end_in(cmd[0]),
        .pc_inc_in(cmd[1]), .jump_in(cmd[2]), .call_in(cmd[3]), .target_addr_in(target),
        .return_plain_in(cmd[4]), .return_restore_status_in(cmd[5]), .acc_in(acc),
        .status_load_in(cmd[6]), .bank_sel_we_in(cmd[7]), .bank_sel_in(bank_sel),
        .alu_flags_we_in(cmd[8]), .carry_in(carry), .aux_carry_in(aux),
        .user_flag_zero_cpl_in(cmd[9]), .user_flag_zero_clr_in(cmd[10]),
        .user_flag_one_cpl_in(cmd[11]), .user_flag_one_clr_in(cmd[12]),
        .ext_irq_enable_instr_in(cmd[13]), .ext_irq_disable_instr_in(cmd[14]),
        .timer_irq_enable_instr_in(cmd[15]), .timer_irq_disable_instr_in(cmd[16]),
        .timer_load_in(cmd[17]), .timer_start_instr_in(cmd[18]),
        .event_count_start_instr_in(cmd[19]), .counter_stop_instr_in(cmd[20]),
        .cond_sel_in(cond_sel), .acc_bit_sel_in(acc_bit_sel), .cond_eval_in(cmd[21]),
        .pc_out(pc), .rom_addr_out(rom), .program_status_word_out(program_status),
        .user_flag_one_out(uf1), .timer_count_out(cnt), .timer_flag_out(tflag),
        .cond_true_out(cond_true), .vector_taken_out(vec), .irq_in_service_out(in_svc));

    initial begin
        forever #10 core_clk_in = ~core_clk_in;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic tick;
        @(posedge core_clk_in);
        #1;
    endtask

    // one-cycle strobe, then an idle edge before the next one
    task automatic pulse(input int b);
        @(posedge core_clk_in);
        cmd <= 22'h1 << b;
        @(posedge core_clk_in);
        cmd <= 22'h0;
        #1;
    endtask

    task automatic push(input logic [11:0] np);
        stk_pc[sp_m] = pc_m;
        stk_up[sp_m] = up_m;
        sp_m = sp_m + 3'h1;
        pc_m = np;
    endtask

    task automatic ret(input int b);
        pulse(b);
        tick;
        sp_m = sp_m - 3'h1;
        pc_m = stk_pc[sp_m];
        if (b == 5)
            up_m = stk_up[sp_m];
    endtask

    task automatic chk_core;
        check(16'(pc), 16'(pc_m));
        check(16'(program_status), 16'({up_m, 1'b1, sp_m}));
    endtask

    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            tally_and_finish;
        end
    end

    initial begin
        repeat (5) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        #1;
        chk_core;
        check(16'({uf1, tflag, in_svc, vec}), 16'h0);
        check(16'(cnt), 16'(MPT_CNT_RESET));
        // flags, bank select and branch conditions
        carry <= 1'b1;
        aux <= 1'b1;
        bank_sel <= 1'b1;
        pulse(8);
        pulse(9);
        pulse(7);
        up_m = 4'hf;
        check(16'(program_status), 16'h00f8);
        pulse(11);
        check(16'(uf1), 16'h1);
        acc <= 8'h04;
        acc_bit_sel <= 3'h2;
        test_a <= 1'b1;
        for (i = 0; i < 13; i++) begin
            cond_sel <= 4'(i);
            #2;
            check(16'(cond_true), 16'((16'h053b >> i) & 16'h0001));
        end
        // nine nested calls wrap the pointer onto the oldest entry
        acc <= 8'ha0;
        pulse(6);
        up_m = 4'ha;
        check(16'(program_status), 16'h00a8);
        for (i = 0; i < 9; i++) begin
            target <= 12'hc10 + 12'(i);
            pulse(3);
            push(12'hc10 + 12'(i));
            chk_core;
            check(16'(rom), 16'(pc_m[9:0]));
        end
        acc <= {4'h5, 1'b0, sp_m};
        pulse(6);
        up_m = 4'h5;
        chk_core;
        ret(4);
        chk_core;
        ret(5);
        chk_core;
        // external interrupt accepted once, ignored while in service
        pulse(13);
        irq_req <= 1'b1;
        repeat (3) tick;
        pulse(0);
        push(MPT_VEC_EXT);
        chk_core;
        check(16'({vec, in_svc}), 16'h3);
        pulse(0);
        chk_core;
        irq_req <= 1'b0;
        repeat (3) tick;
        ret(5);
        chk_core;
        check(16'(in_svc), 16'h0);
        // disabled input stays testable only
        pulse(14);
        irq_req <= 1'b1;
        repeat (3) tick;
        cond_sel <= 4'hb;
        pulse(0);
        chk_core;
        check(16'(cond_true), 16'h1);
        irq_req <= 1'b0;
        repeat (3) tick;
        // timer mode, overflow and priority against the external request
        pulse(15);
        acc <= 8'hfe;
        pulse(17);
        check(16'(cnt), 16'h00fe);
        pulse(18);
        n = 0;
        while (cnt !== 8'hff && n < 40) begin
            tick;
            n++;
        end
        n = 0;
        while (cnt !== 8'h00 && n < 40) begin
            tick;
            n++;
        end
        check(16'(n), 16'(MPT_PRESCALE));
        tick;
        check(16'(tflag), 16'h1);
        pulse(13);
        irq_req <= 1'b1;
        repeat (3) tick;
        pulse(0);
        push(MPT_VEC_EXT);
        chk_core;
        irq_req <= 1'b0;
        repeat (3) tick;
        ret(5);
        pulse(0);
        push(MPT_VEC_TMR);
        chk_core;
        ret(5);
        pulse(0);
        chk_core;
        pulse(20);
        cond_sel <= 4'h6;
        #2;
        check(16'(cond_true), 16'h1);
        pulse(21);
        check(16'(tflag), 16'h0);
        // event mode: one falling edge wraps the counter
        acc <= 8'hff;
        pulse(17);
        pulse(19);
        ev_req <= 1'b1;
        tick;
        ev_req <= 1'b0;
        repeat (5) tick;
        check(16'({tflag, cnt}), 16'h0100);
        pulse(20);
        ev_req <= 1'b1;
        tick;
        ev_req <= 1'b0;
        repeat (6) tick;
        check(16'(cnt), 16'h0000);
        // increment, jump, flag clears, timer request dropped by disable
        pulse(1);
        pc_m = pc_m + 12'h001;
        chk_core;
        target <= 12'h5a5;
        pulse(2);
        pc_m = 12'h5a5;
        chk_core;
        check(16'(rom), 16'h01a5);
        pulse(10);
        pulse(12);
        up_m = up_m & 4'hd;
        chk_core;
        check(16'(uf1), 16'h0);
        pulse(16);
        pulse(15);
        pulse(0);
        chk_core;
        check(16'({vec, in_svc}), 16'h0);
        tally_and_finish;
    end
endmodule
